// [adcc_pkg.sv]
// package: register map, field layouts and timing of the converter control
package adcc_pkg;
    // register byte addresses
    localparam logic [7:0] CFG_ADDR  = 8'hef;
    localparam logic [7:0] MODE_ADDR = 8'hd8;
    localparam logic [7:0] CAL_ADDR  = 8'hf5;
    // reset values
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CAL_RST  = 8'h00;

    // converter_config_reg layout
    typedef struct packed {
        logic       pwr_up;
        logic       ext_ref;
        logic [1:0] conv_clock_div;
        logic [1:0] acquire_time;
        logic       timer_trigger_enable;
        logic       external_trigger_enable;
    } adcc_cfg_t;

    // channel_mode_reg layout
    typedef struct packed {
        logic       conversion_done_flag;
        logic       dma_en;
        logic       continuous_convert_bit;
        logic       single_convert_bit;
        logic [3:0] channel_select;
    } adcc_mode_t;

    // calibration_ctrl_reg layout, bit 7 is the read-only busy
    typedef struct packed {
        logic       busy;
        logic       gain_cal_disable;
        logic [1:0] average_count;
        logic       rsvd_zero;
        logic       rsvd_one;
        logic       cal_type;
        logic       start_calibration_bit;
    } adcc_cal_t;

    // channel codes
    localparam logic [3:0] CH_EXT_LAST = 4'h7;
    localparam logic [3:0] CH_TEMP     = 4'h8;
    localparam logic [3:0] CH_DAC0     = 4'h9;
    localparam logic [3:0] CH_DAC1     = 4'ha;
    localparam logic [3:0] CH_GND      = 4'hb;
    localparam logic [3:0] CH_REF      = 4'hc;
    localparam logic [3:0] CH_STOP     = 4'hf;

    // conversion timing in converter clocks
    localparam logic [4:0] CONV_CLKS = 5'h0f;
    localparam logic [4:0] SYNC_CLKS = 5'h01;
    // master clock dividers for codes 00,01,10,11
    localparam logic [5:0] DIV_C0 = 6'h08;
    localparam logic [5:0] DIV_C1 = 6'h04;
    localparam logic [5:0] DIV_C2 = 6'h10;
    localparam logic [5:0] DIV_C3 = 6'h20;
    // calibration averages for codes 00,01,10,11
    localparam logic [5:0] AVG_C0 = 6'h0f;
    localparam logic [5:0] AVG_C1 = 6'h01;
    localparam logic [5:0] AVG_C2 = 6'h1f;
    localparam logic [5:0] AVG_C3 = 6'h3f;

    // convert-start pin least low time
    localparam int CLK_PERIOD_NS  = 100;
    localparam int CONVERT_START_PIN_MIN_NS  = 100;
    localparam int CONVERT_START_PIN_MIN_CYC_I =
        (CONVERT_START_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CONVERT_START_PIN_MIN_CYC =
        (CONVERT_START_PIN_MIN_CYC_I < 1) ? 4'h1 : CONVERT_START_PIN_MIN_CYC_I[3:0];

    // controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CAL  = 3'b100
    } adcc_state_t;
endpackage

// [adcc_ctrl.sv]
// converter control: channel/mode, triggers, timing and calibration sequencer
`timescale 1ns/10ps

// Summary of operation
// - done flag on conversion end or DMA block
// - interrupt vector clears the done flag
// - DMA bit cleared by hardware at completion
// - DMA bit stops address strobe until start
// - single bit launches exactly one conversion
// - outside DMA channel comes from register
// - in DMA channel comes from memory
// - channel codes decoded, others reserved
// - stop code ends the DMA sequence
// - busy set during conversion or calibration
// - gain disable bit suppresses gain calibration
// - averages 15, 1, 31, 63 by code
// - type bit picks offset or gain
// - start calibration bit, cleared when done
// - conversion is 15 plus 1 plus acquisition
// - config bit six selects external reference
// - divide field gives 8, 4, 16, 32
// - acquisition field gives 1 to 4 clocks
// - timer overflow starts conversion when enabled
// - low convert-start pulse starts conversion
module adcc_ctrl (
    // clock, reset, enable
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ce,
    // special function register port
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_sfr_rd,
    output logic      [7:0] o_sfr_rdata,
    // core events and triggers
    input  wire logic       i_int_ack,
    input  wire logic       i_t2_ovf,
    input  wire logic       i_convert_start_pin_n,
    // channel identifier fetched from external memory
    input  wire logic [3:0] i_dma_chan_id,
    // converter side
    output logic      [3:0] o_channel,
    output logic            o_chan_valid,
    output logic            o_track,
    output logic            o_conv_done,
    output logic            o_cal_active,
    output logic            o_cal_gain,
    output logic            o_ext_ref,
    output logic            o_busy,
    output logic            o_irq_flag,
    output logic            o_dma_active,
    output logic            o_ale_en
);
    adcc_pkg::adcc_cfg_t   cfg_r;
    adcc_pkg::adcc_mode_t  mode_r;
    adcc_pkg::adcc_cal_t   cal_r;
    adcc_pkg::adcc_state_t st_r;
    logic [5:0] div_cnt_r;
    logic [4:0] tck_r;
    logic [5:0] rd_cnt_r;
    logic       trig_r;
    logic       sync1_r;
    logic       sync2_r;
    logic [3:0] low_cnt_r;
    logic       dma_run_r;

    function automatic logic [5:0] div_of(input logic [1:0] c);
        case (c)
            2'b00:   div_of = adcc_pkg::DIV_C0;
            2'b01:   div_of = adcc_pkg::DIV_C1;
            2'b10:   div_of = adcc_pkg::DIV_C2;
            default: div_of = adcc_pkg::DIV_C3;
        endcase
    endfunction

    function automatic logic [5:0] avg_of(input logic [1:0] c);
        case (c)
            2'b00:   avg_of = adcc_pkg::AVG_C0;
            2'b01:   avg_of = adcc_pkg::AVG_C1;
            2'b10:   avg_of = adcc_pkg::AVG_C2;
            default: avg_of = adcc_pkg::AVG_C3;
        endcase
    endfunction

    function automatic logic chan_ok(input logic [3:0] c);
        chan_ok = (c <= adcc_pkg::CH_EXT_LAST) || (c == adcc_pkg::CH_TEMP)
               || (c == adcc_pkg::CH_DAC0) || (c == adcc_pkg::CH_DAC1)
               || (c == adcc_pkg::CH_GND) || (c == adcc_pkg::CH_REF);
    endfunction

    // register decode
    wire        wr_cfg  = i_sfr_wr && (i_sfr_addr == adcc_pkg::CFG_ADDR);
    wire        wr_mode = i_sfr_wr && (i_sfr_addr == adcc_pkg::MODE_ADDR);
    wire        wr_cal  = i_sfr_wr && (i_sfr_addr == adcc_pkg::CAL_ADDR);
    wire adcc_pkg::adcc_mode_t wmode = i_sfr_wdata;
    wire adcc_pkg::adcc_cal_t  wcal  = i_sfr_wdata;
    wire [7:0]  rd_mux =
        (i_sfr_addr == adcc_pkg::CFG_ADDR)  ? cfg_r :
        (i_sfr_addr == adcc_pkg::MODE_ADDR) ? mode_r :
        (i_sfr_addr == adcc_pkg::CAL_ADDR)  ? {o_busy, cal_r[6:0]} : 8'h00;

    // converter clock tick from the master clock
    wire [5:0]  div_n   = div_of(cfg_r.conv_clock_div);
    wire        tick    = (div_cnt_r == div_n - 6'h01);
    wire [4:0]  acq_n   = {3'b000, cfg_r.acquire_time} + 5'h01;
    wire [4:0]  conv_n  = adcc_pkg::CONV_CLKS + adcc_pkg::SYNC_CLKS + acq_n;
    wire        last_tk = tick && (tck_r == conv_n - 5'h01);
    wire        idle    = (st_r == adcc_pkg::ST_IDLE);

    // convert-start pin held low long enough
    wire        pin_trig = cfg_r.external_trigger_enable && !sync2_r
                        && (low_cnt_r == adcc_pkg::CONVERT_START_PIN_MIN_CYC - 4'h1);
    wire        t2_trig  = cfg_r.timer_trigger_enable && i_t2_ovf;
    wire        want    = mode_r.continuous_convert_bit
                       || mode_r.single_convert_bit || trig_r;
    wire [3:0]  chan_sel = mode_r.dma_en ? i_dma_chan_id
                                         : mode_r.channel_select;
    wire        dma_stop = idle && want && mode_r.dma_en
                        && (i_dma_chan_id == adcc_pkg::CH_STOP);
    wire        go_cal  = idle && cal_r.start_calibration_bit;
    wire        go_conv = idle && !go_cal && want && !dma_stop;
    // gain with disable set skips the readings
    wire        cal_skip = cal_r.cal_type && cal_r.gain_cal_disable;
    wire [5:0]  cal_rds  = avg_of(cal_r.average_count);
    wire        conv_end = (st_r == adcc_pkg::ST_CONV) && last_tk;
    wire        cal_end  = (st_r == adcc_pkg::ST_CAL)
                        && (cal_skip || (last_tk && rd_cnt_r == cal_rds));
    wire        blk_end  = dma_stop;
    wire        flag_set = (conv_end && !mode_r.dma_en) || blk_end;

    // pin synchroniser, second stage alone feeds the filter
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_r   <= 1'b1;
            sync2_r   <= 1'b1;
            low_cnt_r <= 4'h0;
        end else if (i_ce) begin
            sync1_r   <= i_convert_start_pin_n;
            sync2_r   <= sync1_r;
            if (sync2_r)
                low_cnt_r <= 4'h0;
            else if (low_cnt_r != adcc_pkg::CONVERT_START_PIN_MIN_CYC)
                low_cnt_r <= low_cnt_r + 4'h1;
        end
    end

    // pending trigger, consumed at the start it causes
    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            trig_r <= 1'b0;
        else if (i_ce)
            trig_r <= pin_trig || t2_trig || (trig_r && !go_conv
                      && !dma_stop);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            cfg_r <= adcc_pkg::CFG_RST;
        else if (i_ce && wr_cfg)
            cfg_r <= i_sfr_wdata;
    end

    // channel and mode register; a hardware set beats a software clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_r <= adcc_pkg::MODE_RST;
        end else if (i_ce) begin
            if (wr_mode)
                mode_r <= wmode;
            // clear by vector or by software write
            if (i_int_ack && !(wr_mode && wmode.conversion_done_flag))
                mode_r.conversion_done_flag <= 1'b0;
            // set on conversion or DMA block end
            if (flag_set)
                mode_r.conversion_done_flag <= 1'b1;
            // DMA bit drops at block end unless rewritten
            if (blk_end && !(wr_mode && wmode.dma_en))
                mode_r.dma_en <= 1'b0;
            // single bit ends with its cycle
            if ((conv_end || blk_end) && !mode_r.continuous_convert_bit
                && !(wr_mode && wmode.single_convert_bit))
                mode_r.single_convert_bit <= 1'b0;
        end
    end

    // calibration register; busy is not stored here
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cal_r <= adcc_pkg::CAL_RST;
        end else if (i_ce) begin
            if (wr_cal)
                cal_r <= {1'b0, wcal[6:0]};
            if (cal_end && !(wr_cal && wcal.start_calibration_bit))
                cal_r.start_calibration_bit <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r      <= adcc_pkg::ST_IDLE;
            div_cnt_r <= 6'h00;
            tck_r     <= 5'h00;
            rd_cnt_r  <= 6'h00;
            dma_run_r <= 1'b0;
        end else if (i_ce) begin
            div_cnt_r <= (idle || tick) ? 6'h00 : div_cnt_r + 6'h01;
            if (tick)
                tck_r <= last_tk ? 5'h00 : tck_r + 5'h01;
            case (st_r)
                adcc_pkg::ST_IDLE: begin
                    tck_r    <= 5'h00;
                    rd_cnt_r <= 6'h01;
                    if (go_cal)
                        st_r <= adcc_pkg::ST_CAL;
                    else if (go_conv)
                        st_r <= adcc_pkg::ST_CONV;
                    if (go_conv && mode_r.dma_en)
                        dma_run_r <= 1'b1;
                    if (blk_end)
                        dma_run_r <= 1'b0;
                end
                adcc_pkg::ST_CONV: begin
                    // back to idle, continuous restarts next cycle
                    if (conv_end)
                        st_r <= adcc_pkg::ST_IDLE;
                end
                adcc_pkg::ST_CAL: begin
                    if (cal_end)
                        st_r <= adcc_pkg::ST_IDLE;
                    else if (last_tk)
                        rd_cnt_r <= rd_cnt_r + 6'h01;
                end
                default: st_r <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sfr_rdata  <= 8'h00;
            o_channel    <= 4'h0;
            o_chan_valid <= 1'b0;
            o_track      <= 1'b0;
            o_conv_done  <= 1'b0;
            o_cal_active <= 1'b0;
            o_cal_gain   <= 1'b0;
            o_ext_ref    <= 1'b0;
            o_busy       <= 1'b0;
            o_irq_flag   <= 1'b0;
            o_dma_active <= 1'b0;
            o_ale_en     <= 1'b1;
        end else if (i_ce) begin
            if (i_sfr_rd)
                o_sfr_rdata <= rd_mux;
            // channel latched at start; calibration uses register code
            if (go_conv || go_cal)
                o_channel <= go_cal ? mode_r.channel_select : chan_sel;
            if (go_conv || go_cal)
                o_chan_valid <= chan_ok(go_cal ? mode_r.channel_select
                                               : chan_sel);
            // sync clock first, then acquisition window
            o_track      <= !idle && !last_tk && (tick ? tck_r + 5'h01
                            : tck_r) >= adcc_pkg::SYNC_CLKS
                            && (tick ? tck_r + 5'h01 : tck_r) <= acq_n;
            o_conv_done  <= conv_end;
            o_cal_active <= (go_cal || st_r == adcc_pkg::ST_CAL)
                            && !cal_end && !cal_skip;
            o_cal_gain   <= cal_r.cal_type;
            o_ext_ref    <= cfg_r.ext_ref;
            o_busy       <= (go_cal || go_conv || !idle)
                            && !conv_end && !cal_end;
            o_irq_flag   <= flag_set || (mode_r.conversion_done_flag
                            && !i_int_ack && !wr_mode) || (wr_mode
                            && wmode.conversion_done_flag);
            o_dma_active <= (dma_run_r || (go_conv && mode_r.dma_en))
                            && !blk_end;
            // strobe off from DMA set until its first start
            o_ale_en     <= !(mode_r.dma_en && !dma_run_r && !go_conv)
                            || blk_end;
        end
    end

    a_busy_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && !idle && !conv_end && !cal_end |=> o_busy)
        else $error("busy low during a cycle");
    a_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && flag_set |=> mode_r.conversion_done_flag)
        else $error("done flag not set");
    a_ack_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && i_int_ack && !flag_set && !wr_mode
        |=> !mode_r.conversion_done_flag)
        else $error("vector did not clear flag");
    a_dma_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && blk_end && !wr_mode |=> !mode_r.dma_en && !o_dma_active)
        else $error("DMA bit survived block end");
    a_ale_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && mode_r.dma_en && !dma_run_r && idle && !want |=> !o_ale_en)
        else $error("strobe ran while DMA armed");
    a_single_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && conv_end && !mode_r.continuous_convert_bit && !wr_mode
        |=> !mode_r.single_convert_bit)
        else $error("single bit not cleared");
    a_cont_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && conv_end && mode_r.continuous_convert_bit && !wr_mode
        |=> mode_r.single_convert_bit == $past(mode_r.single_convert_bit))
        else $error("single bit cleared in continuous");
    a_start_calibration_bit_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && cal_end && !wr_cal |=> !cal_r.start_calibration_bit)
        else $error("start calibration not cleared");
    a_conv_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && conv_end |-> tck_r == 5'h0f + 5'h01 + acq_n - 5'h01)
        else $error("conversion length wrong");
    a_chan_src: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce && go_conv && mode_r.dma_en |=> o_channel == $past(i_dma_chan_id))
        else $error("DMA channel not from memory");
endmodule // adcc_ctrl

// [adcc_core_model.sv]
// core-side model: drives the special function register port
`timescale 1ns/10ps
module adcc_core_model (
    // clock
    input  wire logic       i_clk,
    // register port toward the device
    output logic      [7:0] o_sfr_addr,
    output logic            o_sfr_wr,
    output logic      [7:0] o_sfr_wdata,
    output logic            o_sfr_rd,
    input  wire logic [7:0] i_sfr_rdata,
    // interrupt vector taken
    output logic            o_int_ack
);
    initial begin
        o_sfr_addr  = 8'h00;
        o_sfr_wr    = 1'b0;
        o_sfr_wdata = 8'h00;
        o_sfr_rd    = 1'b0;
        o_int_ack   = 1'b0;
    end

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_sfr_addr  <= a;
        o_sfr_wdata <= d;
        o_sfr_wr    <= 1'b1;
        @(posedge i_clk);
        o_sfr_wr    <= 1'b0;
        // released data never shows the value just written
        o_sfr_wdata <= ~d;
    endtask

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_sfr_addr <= a;
        o_sfr_rd   <= 1'b1;
        @(posedge i_clk);
        o_sfr_rd <= 1'b0;
        #1;
        d = i_sfr_rdata;
    endtask

    task automatic vector;
        @(posedge i_clk);
        o_int_ack <= 1'b1;
        @(posedge i_clk);
        o_int_ack <= 1'b0;
    endtask

    task automatic cal(input logic g, input logic [1:0] v, input logic t);
        sfr_wr(adcc_pkg::CAL_ADDR, {1'b0, g, v, 2'b01, t, 1'b1});
    endtask
endmodule // adcc_core_model

// [test_adcc_ctrl.sv]
// testbench: register-driven conversion, trigger, calibration, dma checks
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module test_adcc_ctrl;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       t2 = 1'b0;
    logic       pin_n = 1'b1;
    logic [3:0] dma_id = 4'h0;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr, rd, ack, seen_cal, seen_gain;
    logic [3:0] ch, o_channel;
    logic       o_chan_valid, o_track, o_conv_done, o_cal_active;
    logic       o_cal_gain, o_ext_ref, o_busy, o_irq_flag;
    logic       o_dma_active, o_ale_en;
    logic [3:0] c;
    int         n_fail = 0;
    int         checked = 0;
    int         n_done = 0;
    int         dv [4];
    int         av [4];
    int         i, n, e, t, l, nt;

    always #50 clk = ~clk;
    always @(posedge clk) if (o_conv_done === 1'b1) n_done++;

    adcc_core_model core (
        .i_clk(clk), .o_sfr_addr(addr), .o_sfr_wr(wr), .o_sfr_wdata(wdata),
        .o_sfr_rd(rd), .i_sfr_rdata(rdata), .o_int_ack(ack));

    adcc_ctrl dut (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd),
        .o_sfr_rdata(rdata), .i_int_ack(ack), .i_t2_ovf(t2),
        .i_convert_start_pin_n(pin_n), .i_dma_chan_id(dma_id),
        .o_channel(o_channel), .o_chan_valid(o_chan_valid),
        .o_track(o_track), .o_conv_done(o_conv_done),
        .o_cal_active(o_cal_active), .o_cal_gain(o_cal_gain),
        .o_ext_ref(o_ext_ref), .o_busy(o_busy), .o_irq_flag(o_irq_flag),
        .o_dma_active(o_dma_active), .o_ale_en(o_ale_en));

    function automatic int clen(input logic [1:0] dc, input logic [1:0] ac);
        return dv[dc] * (int'(adcc_pkg::CONV_CLKS) +
                         int'(adcc_pkg::SYNC_CLKS) + int'(ac) + 1);
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // bounded wait for a cycle to start, then count its busy cycles
    task automatic run_len(output int m);
        int k;
        m = 0;
        k = 0;
        seen_cal = 1'b0;
        seen_gain = 1'b0;
        nt = 0;
        while (o_busy !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        while (o_busy === 1'b1 && m < 9000) begin
            seen_cal = seen_cal | o_cal_active;
            // gain counts only while a calibration really runs
            seen_gain = seen_gain | (o_cal_gain & o_cal_active);
            if (o_track === 1'b1)
                nt++;
            tick(1);
            m++;
        end
    endtask

    task automatic test_done;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        test_done;
    end

    initial begin
        dv = '{int'(adcc_pkg::DIV_C0), int'(adcc_pkg::DIV_C1),
               int'(adcc_pkg::DIV_C2), int'(adcc_pkg::DIV_C3)};
        av = '{int'(adcc_pkg::AVG_C0), int'(adcc_pkg::AVG_C1),
               int'(adcc_pkg::AVG_C2), int'(adcc_pkg::AVG_C3)};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        core.sfr_wr(adcc_pkg::CAL_ADDR, 8'h80);
        core.sfr_rd(adcc_pkg::CAL_ADDR, d);
        `CHK(d, adcc_pkg::CAL_RST)
        core.sfr_rd(adcc_pkg::MODE_ADDR, d);
        `CHK(d, adcc_pkg::MODE_RST)
        core.sfr_rd(8'hd9, d);
        `CHK(d, 8'h00)
        `CHK(o_ale_en, 1'b1)
        // every divide and acquisition code, single start each
        for (i = 0; i < 16; i++) begin
            c = i[3:0];
            ch = (i == 15) ? adcc_pkg::CH_TEMP : 4'(i % 8);
            core.sfr_wr(adcc_pkg::CFG_ADDR, {2'b10, c, 2'b00});
            core.sfr_wr(adcc_pkg::MODE_ADDR, {4'h1, ch});
            run_len(n);
            e = clen(c[3:2], c[1:0]);
            `CHK(n >= e - 3 && n <= e + 3, 1'b1)
            t = dv[c[3:2]] * (int'(c[1:0]) + 1);
            `CHK(nt >= t - 1 && nt <= t + 1, 1'b1)
            `CHK(o_channel, ch)
            `CHK(o_chan_valid, 1'b1)
            core.sfr_rd(adcc_pkg::MODE_ADDR, d);
            `CHK(d, {4'h8, ch})
            `CHK(o_busy, 1'b0)
            core.sfr_wr(adcc_pkg::MODE_ADDR, {4'h0, ch});
        end
        l = clen(2'b01, 2'b00);
        core.sfr_wr(adcc_pkg::CFG_ADDR, 8'h90);
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h12);
        run_len(n);
        `CHK(o_irq_flag, 1'b1)
        core.vector;
        core.sfr_rd(adcc_pkg::MODE_ADDR, d);
        `CHK(d, 8'h02)
        `CHK(o_irq_flag, 1'b0)
        // continuous together with single: runs until cleared
        t = n_done;
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h31);
        tick(3 * l + l / 2);
        `CHK(n_done - t, 3)
        `CHK(o_busy, 1'b1)
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h01);
        run_len(n);
        tick(10);
        `CHK(o_busy, 1'b0)
        core.sfr_rd(adcc_pkg::MODE_ADDR, d);
        `CHK(d, 8'h81)
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h01);
        // timer and pin triggers, disabled then enabled
        for (i = 0; i < 4; i++) begin
            core.sfr_wr(adcc_pkg::CFG_ADDR, {6'h24, i[1] & ~i[0], i[1] & i[0]});
            @(posedge clk);
            // pin low two cycles, timer pulse one cycle
            t2 <= ~i[0];
            pin_n <= ~i[0];
            @(posedge clk);
            t2 <= 1'b0;
            @(posedge clk);
            pin_n <= 1'b1;
            run_len(n);
            `CHK(n >= l - 3 && n <= l + 3, i[1])
        end
        // calibration: averaging codes, offset, gain, gain disabled
        core.sfr_wr(adcc_pkg::CFG_ADDR, 8'h90);
        for (i = 0; i < 6; i++) begin
            c = i[3:0];
            ch = (i < 4) ? adcc_pkg::CH_GND : adcc_pkg::CH_REF;
            core.sfr_wr(adcc_pkg::MODE_ADDR, {4'h0, ch});
            if (i > 3) c[1:0] = 2'b01;
            core.cal(i == 5, c[1:0], i > 3);
            run_len(n);
            e = (i == 5) ? 0 : av[c[1:0]] * l;
            t = (i == 5) ? 2 : av[c[1:0]] * 3 + 4;
            `CHK(n >= e - t && n <= e + t, 1'b1)
            `CHK(seen_cal, i != 5)
            `CHK(seen_gain, i == 4)
            `CHK(o_channel, ch)
            core.sfr_rd(adcc_pkg::CAL_ADDR, d);
            `CHK(d, {1'b0, i == 5, c[1:0], 2'b01, i > 3, 1'b0})
        end
        // dma: strobe held off, memory channel, stop code
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h40);
        // memory id changes on the edge, as a level
        dma_id <= 4'h3;
        tick(2);
        `CHK(o_ale_en, 1'b0)
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h5c);
        run_len(n);
        `CHK(o_channel, 4'h3)
        `CHK(o_ale_en, 1'b1)
        `CHK(o_dma_active, 1'b1)
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h5c);
        dma_id <= adcc_pkg::CH_STOP;
        tick(20);
        `CHK(o_busy, 1'b0)
        `CHK(o_dma_active, 1'b0)
        `CHK(o_ale_en, 1'b1)
        core.sfr_rd(adcc_pkg::MODE_ADDR, d);
        `CHK(d & 8'hc0, 8'h80)
        for (i = 0; i < 2; i++) begin
            core.sfr_wr(adcc_pkg::CFG_ADDR, {1'b1, i[0], 6'h00});
            tick(2);
            `CHK(o_ext_ref, i[0])
        end
        // reserved code converts but is flagged
        core.sfr_wr(adcc_pkg::MODE_ADDR, 8'h1d);
        run_len(n);
        `CHK(o_channel, 4'hd)
        `CHK(o_chan_valid, 1'b0)
        test_done;
    end
endmodule // test_adcc_ctrl
